// ==== common/dcd_pkg.sv ====
// Operation
// RL1 - byte 00 is chip reset, byte 01 deselects every drive
// RL2 - 0000001x is restore; bit 0 picks buffered or normal seek
// RL3 - 0000010x steps in one cylinder, 0000011x steps out one cylinder
// RL4 - 0001xxxx polls drives; bits 3..0 enable polling of drives 3..0
// RL5 - 001xxxxx selects drive; bit 4 head-load delay, low bits type and unit
// RL6 - 0100xxxx sets the register pointer to the low four bits
// RL7 - 01010xxx seek/read ID; step enable, wait complete, verify ID
// RL8 - 0101100x reads physical sectors; bit 0 enables transfer
// RL9 - 0101101x reads track; bit 0 all data or only ID fields
// RL10 - 010111xx reads logical sectors; bit 1 no implied seek, bit 0 transfer
// RL11 - 011xxxxx formats track; deleted mark, reduced current, precomp value
// RL12 - 1xxxxxxx writes sectors; seek off, logical, marks, current, precomp
// RL13 - 00001xxx tape backup; host supplies precomp or zeros in bits 1..0; code latches bits 2..0 as precomp
// RL14 - size code gives 128 shl code bytes; codes 4..7 hard disk only
// RL15 - ECC type 0000,1111,1110,1101 means 4,5,6,7 ECC bytes
// RL16 - five to seven ECC bytes need external ECC logic; code raises eccExternal only in hard disk selectable formats
// RL17 - fixed-size head byte: 0, size bits 1..0, cylinder bit 8, head
// RL18 - selectable-size head byte: bad flag, cylinder bits 10..8, head
// RL19 - selectable ID: ident, cylinder, head, sector, ECC type and size
// RL20 - single-density ID: track, side, sector, size byte low three bits
// RL21 - double-density ID: ident, track, side, sector, size byte
// RL22 - command is one host byte decoded top bits first, first match wins
package dcd_pkg;
  typedef enum logic [3:0] {
    DCD_NONE = 4'h0, DCD_RESET = 4'h1, DCD_DESEL = 4'h2, DCD_RESTORE = 4'h3,
    DCD_STEPIN = 4'h4, DCD_STEPOUT = 4'h5, DCD_POLL = 4'h6, DCD_SELECT = 4'h7,
    DCD_SETPTR = 4'h8, DCD_SEEKID = 4'h9, DCD_RDPHYS = 4'hA, DCD_RDTRK = 4'hB,
    DCD_RDLOG = 4'hC, DCD_FORMAT = 4'hD, DCD_WRITE = 4'hE, DCD_TAPE = 4'hF
  } dcd_cmd_e;
  // register map, byte addresses
  localparam logic [11:0] DCD_CMD_OFS = 12'h000;
  localparam logic [11:0] DCD_DEC_OFS = 12'h004;
  localparam logic [11:0] DCD_FLD_OFS = 12'h008;
  localparam logic [11:0] DCD_IDIN_OFS = 12'h00C;
  localparam logic [11:0] DCD_IDOUT_OFS = 12'h010;
  localparam logic [11:0] DCD_ID2_OFS = 12'h014;
  localparam logic [7:0] DCD_CMD_RST = 8'hFF;
  localparam logic [3:0] DCD_ECC4 = 4'h0;
  localparam logic [3:0] DCD_ECC5 = 4'hF;
  localparam logic [3:0] DCD_ECC6 = 4'hE;
  localparam logic [3:0] DCD_ECC7 = 4'hD;
  localparam logic [14:0] DCD_SIZE_BASE = 15'h0080;
  localparam int DCD_FD_MAXCODE = 3;
endpackage : dcd_pkg

// ==== src/dcd_top.sv ====
`timescale 1ns/10ps
module dcd_top
  import dcd_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // decoded command pulses and fields
  output logic cmdStrobe,
  output logic [3:0] cmdCode,
  output logic chipReset,
  output logic eccExternal
);
  typedef struct packed {
    logic [7:0] cmd;
    logic [3:0] code;
    logic strobe;
    logic [31:0] rdata;
    logic [3:0] regPtr;
    logic [3:0] pollMask;
    logic [4:0] selDrive;
    logic buffered;
    logic [2:0] seekFlags;
    logic [4:0] wrFlags;
    logic [2:0] precomp;
    logic [1:0] rdFlags;
    logic [31:0] idIn;
  } dcd_state_s;
  dcd_state_s st;
  dcd_state_s next_st;
  logic wrAcc;
  logic rdAcc;
  logic cmdWr;
  logic [3:0] dec;
  logic [2:0] sizeCode;
  logic [3:0] eccType;
  logic hardDisk;
  logic userFmt;
  logic [14:0] sectorBytes;
  logic sizeValid;
  logic [2:0] eccBytes;
  logic eccValid;
  logic [7:0] headFixed;
  logic [7:0] headUser;
  logic [7:0] sizeByte;

  // access phase strobes; zero wait states
  assign wrAcc = psel && penable && pwrite;
  assign rdAcc = psel && penable && !pwrite;
  assign cmdWr = wrAcc && paddr == DCD_CMD_OFS;
  assign pready = 1'b1;
  assign pslverr = 1'b0;

  // decode from the top bits down, first match wins
  function automatic logic [3:0] decode(input logic [7:0] c);
    logic [3:0] r;
    r = DCD_NONE;
    if (c[7]) r = DCD_WRITE; // RL22 RL12
    else if (c[6:5] == 2'b11) r = DCD_FORMAT; // RL11
    else if (c[6:4] == 3'b101 && c[3:2] == 2'b11) r = DCD_RDLOG; // RL10
    else if (c[6:1] == 6'b101101) r = DCD_RDTRK; // RL9
    else if (c[6:1] == 6'b101100) r = DCD_RDPHYS; // RL8
    else if (c[6:3] == 4'b1010) r = DCD_SEEKID; // RL7
    else if (c[6:4] == 3'b100) r = DCD_SETPTR; // RL6
    else if (c[6:5] == 2'b01) r = DCD_SELECT; // RL5
    else if (c[6:4] == 3'b001) r = DCD_POLL; // RL4
    else if (c[6:3] == 4'b0001) r = DCD_TAPE; // RL13
    else if (c[6:1] == 6'b000011) r = DCD_STEPOUT; // RL3
    else if (c[6:1] == 6'b000010) r = DCD_STEPIN; // RL3
    else if (c[6:1] == 6'b000001) r = DCD_RESTORE; // RL2
    else if (c[0]) r = DCD_DESEL; // RL1
    else r = DCD_RESET; // RL1
    return r;
  endfunction : decode

  assign dec = decode(pwdata[7:0]);

  // id field helpers from the id input register
  assign hardDisk = st.idIn[31];
  assign userFmt = st.idIn[30];
  assign sizeCode = st.idIn[2:0];
  assign eccType = st.idIn[7:4];
  assign sectorBytes = DCD_SIZE_BASE << sizeCode; // RL14
  assign sizeValid = hardDisk || (int'(sizeCode) <= DCD_FD_MAXCODE); // RL14

  // ecc type to byte count; unlisted codes flag invalid
  always_comb begin
    eccBytes = 3'h4;
    eccValid = 1'b1;
    unique case (eccType)
      DCD_ECC4: eccBytes = 3'h4; // RL15
      DCD_ECC5: eccBytes = 3'h5; // RL15
      DCD_ECC6: eccBytes = 3'h6; // RL15
      DCD_ECC7: eccBytes = 3'h7; // RL15
      default: eccValid = 1'b0;
    endcase
  end
  // only the four byte code is internal, rest needs outside help in hard disk selectable formats
  assign eccExternal = hardDisk && userFmt && eccValid && (eccType != DCD_ECC4); // RL16

  // head bytes built from cylinder [18:8], head [23:20], bad flag [24]
  assign headFixed = {1'b0, sizeCode[1:0], st.idIn[16], st.idIn[23:20]}; // RL17
  assign headUser = {st.idIn[24], st.idIn[18:16], st.idIn[23:20]}; // RL18
  assign sizeByte = {eccType, 1'b0, sizeCode}; // RL19

  // next state
  always_comb begin
    next_st = st;
    next_st.strobe = 1'b0;
    if (wrAcc && paddr == DCD_CMD_OFS) begin
      next_st.cmd = pwdata[7:0]; // RL22
      next_st.code = dec;
      next_st.strobe = 1'b1;
      unique case (dec)
        DCD_RESTORE, DCD_STEPIN, DCD_STEPOUT: next_st.buffered = pwdata[0]; // RL2 RL3
        DCD_POLL: next_st.pollMask = pwdata[3:0]; // RL4
        DCD_SELECT: next_st.selDrive = pwdata[4:0]; // RL5
        DCD_SETPTR: next_st.regPtr = pwdata[3:0]; // RL6
        DCD_SEEKID: next_st.seekFlags = pwdata[2:0]; // RL7
        DCD_RDPHYS, DCD_RDTRK: next_st.rdFlags = {1'b0, pwdata[0]}; // RL8 RL9
        DCD_RDLOG: next_st.rdFlags = pwdata[1:0]; // RL10
        DCD_FORMAT: begin
          next_st.wrFlags = {3'h0, pwdata[4:3]}; // RL11
          next_st.precomp = pwdata[2:0];
        end
        DCD_WRITE: begin
          next_st.wrFlags = {pwdata[6:5], 1'b1, pwdata[4:3]}; // RL12
          next_st.precomp = pwdata[2:0];
        end
        DCD_TAPE: next_st.precomp = pwdata[2:0]; // RL13
        DCD_RESET: begin
          next_st.pollMask = 4'h0; // RL1
          next_st.selDrive = 5'h00;
          next_st.regPtr = 4'h0;
        end
        DCD_DESEL: next_st.selDrive = 5'h00; // RL1
        default: next_st.code = DCD_NONE;
      endcase
    end
    if (wrAcc && paddr == DCD_IDIN_OFS) next_st.idIn = pwdata;
    // read mux, registered for a flop-driven data bus
    next_st.rdata = 32'h0;
    if (psel && !penable && !pwrite) begin
      unique case (paddr)
        DCD_CMD_OFS: next_st.rdata = {24'h0, st.cmd};
        DCD_DEC_OFS: next_st.rdata = {20'h0, st.regPtr, st.pollMask, st.code};
        DCD_FLD_OFS: next_st.rdata = {9'h0, st.selDrive, st.buffered, st.seekFlags,
                                      st.wrFlags, st.precomp, st.rdFlags, 4'h0};
        DCD_IDIN_OFS: next_st.rdata = st.idIn;
        DCD_IDOUT_OFS: next_st.rdata = {eccValid, eccBytes, sizeValid, sectorBytes,
                                        headUser, 2'h0, eccExternal, 1'b0};
        DCD_ID2_OFS: next_st.rdata = {8'h0, sizeByte, headFixed,
                                      5'h00, sizeCode}; // RL20 RL21
        default: next_st.rdata = 32'h0;
      endcase
    end
  end

  // single state register
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      st <= '0;
      st.cmd <= DCD_CMD_RST;
    end else begin
      st <= next_st;
    end
  end

  assign prdata = st.rdata;
  assign cmdStrobe = st.strobe;
  assign cmdCode = st.code;
  assign chipReset = st.strobe && st.code == DCD_RESET;

  // each command byte is judged one cycle after the write lands
  chk_reset_cmd: assert property (@(posedge clock) disable iff (!arst_n) // RL1
    cmdWr && pwdata[7:0] == 8'h00
      |=> chipReset)
    else $error("zero byte did not reset");

  chk_reset_clear: assert property (@(posedge clock) disable iff (!arst_n) // RL1
    cmdWr && pwdata[7:0] == 8'h00
      |=> st.pollMask == 4'h0 && st.selDrive == 5'h00 && st.regPtr == 4'h0)
    else $error("chip reset left state");

  chk_desel_dec: assert property (@(posedge clock) disable iff (!arst_n) // RL1
    cmdWr && pwdata[7:0] == 8'h01
      |=> cmdCode == DCD_DESEL && !chipReset)
    else $error("deselect not decoded");

  chk_desel_drive: assert property (@(posedge clock) disable iff (!arst_n) // RL1
    cmdWr && pwdata[7:0] == 8'h01
      |=> st.selDrive == 5'h00)
    else $error("drive still selected");

  chk_restore_dec: assert property (@(posedge clock) disable iff (!arst_n) // RL2
    cmdWr && pwdata[7:1] == 7'h01
      |=> cmdCode == DCD_RESTORE)
    else $error("restore not decoded");

  chk_restore_mode: assert property (@(posedge clock) disable iff (!arst_n) // RL2
    cmdWr && pwdata[7:1] == 7'h01
      |=> st.buffered == $past(pwdata[0]))
    else $error("restore seek mode wrong");

  chk_stepin_dec: assert property (@(posedge clock) disable iff (!arst_n) // RL3
    cmdWr && pwdata[7:1] == 7'h02
      |=> cmdCode == DCD_STEPIN)
    else $error("step in not decoded");

  chk_stepout_dec: assert property (@(posedge clock) disable iff (!arst_n) // RL3
    cmdWr && pwdata[7:1] == 7'h03
      |=> cmdCode == DCD_STEPOUT)
    else $error("step out not decoded");

  chk_step_mode: assert property (@(posedge clock) disable iff (!arst_n) // RL3
    cmdWr && pwdata[7:2] == 6'h01
      |=> st.buffered == $past(pwdata[0]))
    else $error("step seek mode wrong");

  chk_poll_dec: assert property (@(posedge clock) disable iff (!arst_n) // RL4
    cmdWr && pwdata[7:4] == 4'h1
      |=> cmdCode == DCD_POLL)
    else $error("poll not decoded");

  chk_poll_mask: assert property (@(posedge clock) disable iff (!arst_n) // RL4
    cmdWr && pwdata[7:4] == 4'h1
      |=> st.pollMask == $past(pwdata[3:0]))
    else $error("poll mask wrong");

  chk_select_dec: assert property (@(posedge clock) disable iff (!arst_n) // RL5
    cmdWr && pwdata[7:5] == 3'h1
      |=> cmdCode == DCD_SELECT)
    else $error("select not decoded");

  chk_select_unit: assert property (@(posedge clock) disable iff (!arst_n) // RL5
    cmdWr && pwdata[7:5] == 3'h1
      |=> st.selDrive == $past(pwdata[4:0]))
    else $error("selected unit wrong");

  chk_ptr_dec: assert property (@(posedge clock) disable iff (!arst_n) // RL6
    cmdWr && pwdata[7:4] == 4'h4
      |=> cmdCode == DCD_SETPTR)
    else $error("pointer set not decoded");

  chk_ptr_load: assert property (@(posedge clock) disable iff (!arst_n) // RL6
    cmdWr && pwdata[7:4] == 4'h4
      |=> st.regPtr == $past(pwdata[3:0]))
    else $error("pointer wrong");

  chk_seek_dec: assert property (@(posedge clock) disable iff (!arst_n) // RL7
    cmdWr && pwdata[7:3] == 5'h0A
      |=> cmdCode == DCD_SEEKID)
    else $error("seek not decoded");

  chk_seek_flags: assert property (@(posedge clock) disable iff (!arst_n) // RL7
    cmdWr && pwdata[7:3] == 5'h0A
      |=> st.seekFlags == $past(pwdata[2:0]))
    else $error("seek flags wrong");

  chk_rdphys_dec: assert property (@(posedge clock) disable iff (!arst_n) // RL8
    cmdWr && pwdata[7:1] == 7'h2C
      |=> cmdCode == DCD_RDPHYS)
    else $error("physical read not decoded");

  chk_rdphys_xfer: assert property (@(posedge clock) disable iff (!arst_n) // RL8
    cmdWr && pwdata[7:1] == 7'h2C
      |=> st.rdFlags == {1'b0, $past(pwdata[0])})
    else $error("physical read transfer wrong");

  chk_rdtrk_dec: assert property (@(posedge clock) disable iff (!arst_n) // RL9
    cmdWr && pwdata[7:1] == 7'h2D
      |=> cmdCode == DCD_RDTRK)
    else $error("track read not decoded");

  chk_rdtrk_mode: assert property (@(posedge clock) disable iff (!arst_n) // RL9
    cmdWr && pwdata[7:1] == 7'h2D
      |=> st.rdFlags[0] == $past(pwdata[0]))
    else $error("track read mode wrong");

  chk_rdlog_dec: assert property (@(posedge clock) disable iff (!arst_n) // RL10
    cmdWr && pwdata[7:2] == 6'h17
      |=> cmdCode == DCD_RDLOG)
    else $error("logical read wrong");

  chk_rdlog_flags: assert property (@(posedge clock) disable iff (!arst_n) // RL10
    cmdWr && pwdata[7:2] == 6'h17
      |=> st.rdFlags == $past(pwdata[1:0]))
    else $error("logical read flags wrong");

  chk_format_dec: assert property (@(posedge clock) disable iff (!arst_n) // RL11
    cmdWr && pwdata[7:5] == 3'h3
      |=> cmdCode == DCD_FORMAT)
    else $error("format not decoded");

  chk_format_flags: assert property (@(posedge clock) disable iff (!arst_n) // RL11
    cmdWr && pwdata[7:5] == 3'h3
      |=> st.wrFlags == {3'h0, $past(pwdata[4:3])} && st.precomp == $past(pwdata[2:0]))
    else $error("format flags wrong");

  chk_write_dec: assert property (@(posedge clock) disable iff (!arst_n) // RL12
    cmdWr && pwdata[7]
      |=> cmdCode == DCD_WRITE)
    else $error("write not decoded");

  chk_write_flags: assert property (@(posedge clock) disable iff (!arst_n) // RL12
    cmdWr && pwdata[7]
      |=> st.wrFlags == {$past(pwdata[6:5]), 1'b1, $past(pwdata[4:3])})
    else $error("write flags wrong");

  chk_write_precomp: assert property (@(posedge clock) disable iff (!arst_n) // RL12
    cmdWr && pwdata[7]
      |=> st.precomp == $past(pwdata[2:0]))
    else $error("write precomp wrong");

  chk_tape_dec: assert property (@(posedge clock) disable iff (!arst_n) // RL13
    cmdWr && pwdata[7:3] == 5'h01
      |=> cmdCode == DCD_TAPE)
    else $error("tape not decoded");

  chk_tape_precomp: assert property (@(posedge clock) disable iff (!arst_n) // RL13
    cmdWr && pwdata[7:3] == 5'h01
      |=> st.precomp == $past(pwdata[2:0]))
    else $error("tape precomp wrong");

  chk_size_min: assert property (@(posedge clock) disable iff (!arst_n) // RL14
    sizeCode == 3'h0
      |-> sectorBytes == DCD_SIZE_BASE)
    else $error("smallest sector size wrong");

  chk_size_max: assert property (@(posedge clock) disable iff (!arst_n) // RL14
    sizeCode == 3'h7
      |-> sectorBytes == 15'h4000)
    else $error("largest sector size wrong");

  chk_floppy_size: assert property (@(posedge clock) disable iff (!arst_n) // RL14
    !hardDisk && sizeCode[2]
      |-> !sizeValid)
    else $error("floppy size code accepted");

  chk_ecc_four: assert property (@(posedge clock) disable iff (!arst_n) // RL15
    eccType == DCD_ECC4
      |-> eccBytes == 3'h4 && eccValid)
    else $error("four byte ecc wrong");

  chk_ecc_seven: assert property (@(posedge clock) disable iff (!arst_n) // RL15
    eccType == DCD_ECC7
      |-> eccBytes == 3'h7 && eccValid)
    else $error("seven byte ecc wrong");

  chk_ecc_ext: assert property (@(posedge clock) disable iff (!arst_n) // RL16
    eccExternal
      |-> eccBytes > 3'h4)
    else $error("external ecc for four bytes");

  chk_head_fixed: assert property (@(posedge clock) disable iff (!arst_n) // RL17
    headFixed[7] == 1'b0
      && headFixed[4] == st.idIn[16])
    else $error("fixed head byte wrong");

  chk_head_user: assert property (@(posedge clock) disable iff (!arst_n) // RL18
    headUser[7] == st.idIn[24]
      && headUser[6:4] == st.idIn[18:16])
    else $error("selectable head byte wrong");

  chk_size_byte: assert property (@(posedge clock) disable iff (!arst_n) // RL19
    sizeByte[2:0] == sizeCode
      && sizeByte[7:4] == eccType)
    else $error("size byte wrong");

  chk_strobe_one: assert property (@(posedge clock) disable iff (!arst_n) // RL22
    cmdStrobe
      |=> !cmdStrobe || $past(wrAcc))
    else $error("strobe stuck");

  chk_rdata_idle: assert property (@(posedge clock) disable iff (!arst_n) // RL22
    !rdAcc
      |-> prdata == 32'h0)
    else $error("read data outside access");
endmodule : dcd_top

// ==== verif/dcd_host_model.sv ====
`timescale 1ns/10ps
module dcd_host_model (
  // clock
  input wire logic clock,
  // apb request and answer
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  input wire logic pready
);
  // idle bus from time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
  end
  // request held until pready seen high, then one idle edge
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d, output bit ok);
    int n;
    ok = 1'b0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    for (n = 0; n < 40 && !ok; n++) begin
      @(posedge clock);
      ok = (pready === 1'b1);
    end
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~d; // stale data must not look valid
    @(posedge clock);
  endtask : xfer
endmodule : dcd_host_model

// ==== verif/testbench.sv ====
`timescale 1ns/10ps
module testbench;
  import dcd_pkg::*;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, cmdStrobe, chipReset, eccExternal;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, word;
  logic [3:0] cmdCode;
  logic [2:0] sz;
  logic ext;
  logic [15:0] lfsr = 16'h775B;
  int fail_count = 0;
  int n_checks = 0;
  dcd_cmd_e expCmd[$];
  logic [31:0] expData[$], expMask[$];
  logic [7:0] cmdTab[21] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07,
    8'h08, 8'h0D, 8'h1A, 8'h2C, 8'h45, 8'h57, 8'h59, 8'h5A, 8'h5B, 8'h5E, 8'h6D,
    8'h9C, 8'hE3};
  logic [3:0] eccTab[4] = '{DCD_ECC4, DCD_ECC5, DCD_ECC6, DCD_ECC7};
  // 50 ns period
  always #25 clock = ~clock;
  dcd_top dcd_top_i (.clock(clock), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cmdStrobe(cmdStrobe), .cmdCode(cmdCode), .chipReset(chipReset),
    .eccExternal(eccExternal));
  dcd_host_model dcd_host_model_i (.clock(clock), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready));
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    n_checks++;
    if (seen !== want) begin
      fail_count++;
      $display("BAD %0t seen %h want %h", $time, seen, want);
    end
  endtask : check
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : report_and_stop
  // independent decoder, top bits first
  function automatic dcd_cmd_e ref_decode(input logic [7:0] c);
    if (c[7]) return DCD_WRITE;
    if (c[6:5] == 2'h3) return DCD_FORMAT;
    if (c[6:4] == 3'h4) return DCD_SETPTR;
    if (c[6:3] == 4'hA) return DCD_SEEKID;
    if (c[6:1] == 6'h2C) return DCD_RDPHYS;
    if (c[6:1] == 6'h2D) return DCD_RDTRK;
    if (c[6:2] == 5'h17) return DCD_RDLOG;
    if (c[6:5] == 2'h1) return DCD_SELECT;
    if (c[6:4] == 3'h1) return DCD_POLL;
    if (c[6:3] == 4'h1) return DCD_TAPE;
    if (c[6:1] == 6'h01) return DCD_RESTORE;
    if (c[6:1] == 6'h02) return DCD_STEPIN;
    if (c[6:1] == 6'h03) return DCD_STEPOUT;
    return c[0] ? DCD_DESEL : DCD_RESET;
  endfunction : ref_decode
  // sixteen bit shift register for the random bytes
  function automatic logic [15:0] lfsr_step(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : lfsr_step
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d,
      input logic [31:0] m);
    bit ok;
    if (!wr) begin
      expData.push_back(d & m);
      expMask.push_back(m);
    end
    dcd_host_model_i.xfer(wr, a, d, ok);
    if (!ok) begin
      fail_count++;
      $display("BAD %0t no pready", $time);
      report_and_stop();
    end
  endtask : bus
  task automatic send_cmd(input logic [7:0] c);
    expCmd.push_back(ref_decode(c));
    bus(1'b1, DCD_CMD_OFS, {24'h000000, c}, 32'h00000000);
  endtask : send_cmd
  // results checked against the oldest note
  always @(posedge clock) begin
    if (cmdStrobe === 1'b1) begin
      if (expCmd.size() == 0) check(32'h1, 32'h0);
      else begin
        check({28'h0, cmdCode}, {28'h0, expCmd[0]});
        check({31'h0, chipReset}, {31'h0, expCmd.pop_front() == DCD_RESET});
      end
    end
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0)
      check(prdata & expMask.pop_front(), expData.pop_front());
  end
  // main sequence
  initial begin
    repeat (10) @(posedge clock);
    arst_n <= 1'b1;
    @(posedge clock);
    bus(1'b0, DCD_CMD_OFS, 32'hFF, 32'hFF);
    foreach (cmdTab[i]) send_cmd(cmdTab[i]);
    bus(1'b0, DCD_FLD_OFS, 32'h0033F8E0, 32'hFFFFFFFF);
    send_cmd(8'h1A);
    bus(1'b0, DCD_DEC_OFS, 32'hA6, 32'hFF);
    send_cmd(8'h45);
    bus(1'b0, DCD_DEC_OFS, 32'h508, 32'hF0F);
    send_cmd(8'h01);
    bus(1'b0, DCD_DEC_OFS, 32'hA2, 32'hFF);
    bus(1'b0, DCD_FLD_OFS, 32'h0003F8E0, 32'hFFFFFFFF);
    send_cmd(8'h00);
    bus(1'b0, DCD_DEC_OFS, 32'h001, 32'hFFF);
    bus(1'b0, 12'hFFC, 32'h0, 32'hFFFFFFFF);
    // random bytes, wide coverage of the decoder
    repeat (200) begin
      lfsr = lfsr_step(lfsr);
      send_cmd(lfsr[7:0]);
    end
    // id fields: bad, head, cylinder, ECC type, size code
    for (int i = 0; i < 8; i++) begin
      lfsr = lfsr_step(lfsr);
      sz = i[2:0];
      ext = (eccTab[i % 4] != DCD_ECC4);
      word = {2'h3, 5'h00, lfsr[15:11], 1'b0, lfsr[10:0], eccTab[i % 4], 1'b0, sz};
      bus(1'b1, DCD_IDIN_OFS, word, 32'h0);
      check({31'h0, eccExternal}, {31'h0, ext});
      bus(1'b0, DCD_IDOUT_OFS, {1'b1, 3'(i % 4 + 4), 1'b1, 15'h0080 << sz, lfsr[15],
        lfsr[10:8], lfsr[14:11], 2'h0, ext, 1'b0}, 32'hFFFFFFFF);
      bus(1'b0, DCD_ID2_OFS, {8'h00, eccTab[i % 4], 1'b0, sz, 1'b0, sz[1:0], lfsr[8],
        lfsr[14:11], 5'h00, sz}, 32'hFFFFFFFF);
    end
    // floppy id: large size codes refused, no outside ecc
    bus(1'b1, DCD_IDIN_OFS, 32'h000000F4, 32'h0);
    check({31'h0, eccExternal}, 32'h0);
    bus(1'b0, DCD_IDOUT_OFS, 32'h0, 32'h08000002);
    bus(1'b1, DCD_IDIN_OFS, 32'h000000F3, 32'h0);
    bus(1'b0, DCD_IDOUT_OFS, 32'h08000000, 32'h08000002);
    repeat (3) @(posedge clock);
    check(expCmd.size(), 0);
    check(expData.size(), 0);
    report_and_stop();
  end
endmodule : testbench
